// ===== src/bbc_config_regs.sv
// Purpose: byte-wide configuration register bank of a buck-boost converter
// Assumes: serial-bus engine outside presents one byte access per strobe
// Notes:   read data registered, valid one cycle after the read strobe
// Notes on behaviour
// - only offsets 1h to 5h are decoded
// - lockout or enable-low returns registers to reset
// - control bit 6 selects low or high span
// - control bit 5 enables converter, variant reset
// - control bit 3 forces fixed-frequency pulse mode
// - control bit 2 enables ramped pulse mode
// - control bits 1-0 choose transition rate
// - any single register accessed on its own
// - status read clears flags unless fault persists
// - select pin picks level a or b
// - target millivolts from range base plus code step
`timescale 1ns/1ps
`include "bbc_consts.svh"
module bbc_config_regs
  import bbc_pkg::*;
#(
  parameter logic       ENABLE_RESET = 1'b1,
  parameter logic [7:0] IDENTITY     = `BBC_ID_DEFAULT // arbitrary value
) (
  input  wire logic       clk_i,
  input  wire logic       sys_rst_i,
  input  wire logic       supply_lockout_i,
  input  wire logic       enable_pin_i,
  input  wire logic [7:0] addr_i,
  input  wire logic       wr_i,
  input  wire logic [7:0] wdata_i,
  input  wire logic       rd_i,
  output logic [7:0]      rdata_o,
  input  wire logic       thermal_fault_i,
  input  wire logic       power_not_good_i,
  input  wire logic       level_select_pin_i,
  output logic            range_high_o,
  output logic            converter_on_o,
  output logic            forced_pulse_mode_o,
  output logic            ramped_pulse_mode_o,
  output bbc_rate_e       rate_o,
  output bbc_level_t      level_code_o,
  output logic [12:0]     target_mv_o
);
  // ********************************
  // reset and decode
  // ********************************
  logic       vol_rst;
  logic [7:0] converter_control;
  bbc_level_t output_level_a;
  bbc_level_t output_level_b;
  logic       flag_thermal;
  logic       flag_not_good;
  logic       status_read;
  logic [7:0] next_rdata;
  logic [12:0] next_target_mv;

  assign vol_rst     = supply_lockout_i || !enable_pin_i;
  assign status_read = rd_i && (addr_i == `BBC_OFF_STATUS);

  // ********************************
  // writable registers
  // ********************************
  // each register written alone, no burst pointer kept
  always_ff @(posedge clk_i) begin
    if (sys_rst_i || vol_rst) begin
      converter_control <= `BBC_RST_CONTROL;
      converter_control[`BBC_CTL_ENABLE] <= ENABLE_RESET;
    end else if (wr_i && addr_i == `BBC_OFF_CONTROL) begin
      converter_control <= wdata_i; // reserved bits stored as written
    end
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i || vol_rst) begin
      output_level_a <= `BBC_RST_LEVEL_A;
    end else if (wr_i && addr_i == `BBC_OFF_LEVEL_A) begin
      output_level_a <= wdata_i[6:0]; // bit 7 read-only
    end
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i || vol_rst) begin
      output_level_b <= `BBC_RST_LEVEL_B;
    end else if (wr_i && addr_i == `BBC_OFF_LEVEL_B) begin
      output_level_b <= wdata_i[6:0];
    end
  end

  // ********************************
  // latched faults
  // ********************************
  bbc_sticky_flag u_thermal (
    .clk_i     (clk_i),
    .sys_rst_i (sys_rst_i),
    .vol_rst_i (vol_rst),
    .fault_i   (thermal_fault_i),
    .clear_i   (status_read),
    .flag_o    (flag_thermal)
  );

  bbc_sticky_flag u_not_good (
    .clk_i     (clk_i),
    .sys_rst_i (sys_rst_i),
    .vol_rst_i (vol_rst),
    .fault_i   (power_not_good_i),
    .clear_i   (status_read),
    .flag_o    (flag_not_good)
  );

  // ********************************
  // read path
  // ********************************
  always_comb begin
    next_rdata = 8'h00;
    unique case (addr_i)
      `BBC_OFF_CONTROL:  next_rdata = converter_control;
      `BBC_OFF_STATUS:   next_rdata = {6'h00, flag_thermal, flag_not_good};
      `BBC_OFF_IDENTITY: next_rdata = IDENTITY;
      `BBC_OFF_LEVEL_A:  next_rdata = {1'b0, output_level_a};
      `BBC_OFF_LEVEL_B:  next_rdata = {1'b0, output_level_b};
      default:           next_rdata = 8'h00;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      rdata_o <= 8'h00;
    end else if (rd_i) begin
      rdata_o <= next_rdata;
    end
  end

  // ********************************
  // converter controls
  // ********************************
  assign range_high_o        = converter_control[`BBC_CTL_RANGE];
  assign converter_on_o      = converter_control[`BBC_CTL_ENABLE];
  assign forced_pulse_mode_o = converter_control[`BBC_CTL_FORCED];
  assign ramped_pulse_mode_o = converter_control[`BBC_CTL_RAMPED];
  assign rate_o = bbc_rate_e'(converter_control[`BBC_CTL_RATE_HI:0]);

  // select pin taken as synchronous; a mid-ramp switch is the stage's concern
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      level_code_o <= `BBC_RST_LEVEL_A;
    end else begin
      level_code_o <= level_select_pin_i ? output_level_b : output_level_a;
    end
  end

  // millivolts keep the 25 mV step exact in integer form
  always_comb begin
    next_target_mv = (converter_control[`BBC_CTL_RANGE] ? `BBC_HIGH_BASE_MV : `BBC_LOW_BASE_MV)
                     + 13'(level_code_o * `BBC_STEP_MV);
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      target_mv_o <= `BBC_LOW_BASE_MV;
    end else begin
      target_mv_o <= next_target_mv;
    end
  end

  // ********************************
  // checks
  // ********************************
  property p_volatile_reset;
    @(posedge clk_i) disable iff (sys_rst_i)
      vol_rst |=> (output_level_a == `BBC_RST_LEVEL_A) && (output_level_b == `BBC_RST_LEVEL_B)
                  && (converter_control[`BBC_CTL_RANGE] == 1'b0);
  endproperty
  a_volatile_reset: assert property (p_volatile_reset) else $error("volatile reset missed");

  property p_enable_reset;
    @(posedge clk_i) disable iff (sys_rst_i)
      vol_rst |=> converter_on_o == ENABLE_RESET;
  endproperty
  a_enable_reset: assert property (p_enable_reset) else $error("enable reset value wrong");

  property p_control_write;
    @(posedge clk_i) disable iff (sys_rst_i)
      (wr_i && addr_i == `BBC_OFF_CONTROL && !vol_rst) |=>
        {range_high_o, converter_on_o, forced_pulse_mode_o, ramped_pulse_mode_o, rate_o}
        == {$past(wdata_i[6]), $past(wdata_i[5]), $past(wdata_i[3:0])};
  endproperty
  a_control_write: assert property (p_control_write) else $error("control field mismatch");

  property p_fault_holds;
    @(posedge clk_i) disable iff (sys_rst_i || vol_rst)
      (status_read && thermal_fault_i) |=> flag_thermal;
  endproperty
  a_fault_holds: assert property (p_fault_holds) else $error("standing fault cleared");

  property p_read_clears;
    @(posedge clk_i) disable iff (sys_rst_i)
      (status_read && !power_not_good_i) |=> !flag_not_good;
  endproperty
  a_read_clears: assert property (p_read_clears) else $error("flag not cleared");

  property p_unmapped_zero;
    @(posedge clk_i) disable iff (sys_rst_i)
      (rd_i && (addr_i == 8'h00 || addr_i > `BBC_OFF_LEVEL_B)) |=> rdata_o == 8'h00;
  endproperty
  a_unmapped_zero: assert property (p_unmapped_zero) else $error("unmapped read nonzero");

  property p_level_pick;
    @(posedge clk_i) disable iff (sys_rst_i)
      1'b1 |=> level_code_o == ($past(level_select_pin_i) ? $past(output_level_b)
                                                          : $past(output_level_a));
  endproperty
  a_level_pick: assert property (p_level_pick) else $error("wrong level register");

  property p_target;
    @(posedge clk_i) disable iff (sys_rst_i)
      ##1 (!range_high_o && $stable(range_high_o)) |=>
        target_mv_o == 13'(`BBC_LOW_BASE_MV + 13'($past(level_code_o) * `BBC_STEP_MV));
  endproperty
  a_target: assert property (p_target) else $error("target voltage wrong");

  property p_identity;
    @(posedge clk_i) disable iff (sys_rst_i)
      (rd_i && addr_i == `BBC_OFF_IDENTITY) |=> rdata_o == IDENTITY;
  endproperty
  a_identity: assert property (p_identity) else $error("identity read wrong");

  c_status_clear: cover property (@(posedge clk_i) flag_thermal ##1 status_read ##1 !flag_thermal);
  c_level_b:      cover property (@(posedge clk_i) level_select_pin_i ##1 level_code_o != 7'h00);
  c_lockout:      cover property (@(posedge clk_i) converter_on_o ##1 supply_lockout_i);
  c_high_range:   cover property (@(posedge clk_i) range_high_o && rate_o == BBC_RATE_10V);
endmodule

// ===== src/bbc_consts.svh
// Purpose: offsets, field positions and reset values of the converter register bank
// Assumes: byte-wide registers at byte offsets
// Notes:   included by the package users only
`ifndef BBC_CONSTS_SVH
`define BBC_CONSTS_SVH
`define BBC_OFF_CONTROL   8'h01
`define BBC_OFF_STATUS    8'h02
`define BBC_OFF_IDENTITY  8'h03
`define BBC_OFF_LEVEL_A   8'h04
`define BBC_OFF_LEVEL_B   8'h05
`define BBC_CTL_RSVD_HI   7
`define BBC_CTL_RANGE     6
`define BBC_CTL_ENABLE    5
`define BBC_CTL_RSVD_LO   4
`define BBC_CTL_FORCED    3
`define BBC_CTL_RAMPED    2
`define BBC_CTL_RATE_HI   1
`define BBC_ST_THERMAL    1
`define BBC_ST_NOT_GOOD   0
`define BBC_RST_CONTROL   8'h00
`define BBC_RST_LEVEL_A   7'h3c
`define BBC_RST_LEVEL_B   7'h42
`define BBC_ID_DEFAULT    8'h15
`define BBC_LOW_BASE_MV   13'h0708
`define BBC_HIGH_BASE_MV  13'h07e9
`define BBC_STEP_MV       13'h0019
`endif

// ===== src/bbc_pkg.sv
// Purpose: shared types of the converter register bank
// Assumes: nothing
// Notes:   constants live in bbc_consts.svh
package bbc_pkg;
  typedef enum logic [1:0] {
    BBC_RATE_1V,
    BBC_RATE_2V5,
    BBC_RATE_5V,
    BBC_RATE_10V
  } bbc_rate_e;
  typedef logic [6:0] bbc_level_t;
endpackage

// ===== src/bbc_sticky_flag.sv
// Purpose: one latched fault flag, cleared by a status read
// Assumes: fault level synchronous to clk_i
// Notes:   set wins over clear; a standing fault keeps the flag up
`timescale 1ns/1ps
module bbc_sticky_flag (
  input  wire logic clk_i,
  input  wire logic sys_rst_i,
  input  wire logic vol_rst_i,
  input  wire logic fault_i,
  input  wire logic clear_i,
  output logic      flag_o
);
  always_ff @(posedge clk_i) begin
    if (sys_rst_i || vol_rst_i) begin
      flag_o <= 1'b0;
    end else if (fault_i) begin
      flag_o <= 1'b1;
    end else if (clear_i) begin
      flag_o <= 1'b0;
    end
  end
endmodule

// ===== verif/bbc_host_model.sv
// Purpose: host model driving the byte register bus of the bank
// Assumes: one byte access per strobe, strobes sampled on rising edges
// Notes:   released data inverted so a stale byte never looks valid
`timescale 1ns/1ps
module bbc_host_model (
  input  wire logic [7:0] rdata_i,
  input  wire logic       clk_i,
  output logic [7:0]      addr_o,
  output logic            wr_o,
  output logic [7:0]      wdata_o,
  output logic            rd_o
);
  initial begin
    addr_o = 8'h01;
    wr_o = 1'b0;
    wdata_o = 8'h00;
    rd_o = 1'b0;
  end
  // single byte per call, never a burst
  // callers write offsets 1h to 5h only; reads also reach 0h and 6h
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_i);
    addr_o <= a;
    // control bits 7 and 4 always sent as zero
    wdata_o <= (a == 8'h01) ? (d & 8'h6f) : d;
    wr_o <= 1'b1;
    @(posedge clk_i);
    wr_o <= 1'b0;
    wdata_o <= ~wdata_o;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk_i);
    addr_o <= a;
    rd_o <= 1'b1;
    @(posedge clk_i);
    rd_o <= 1'b0;
    #1;
    d = rdata_i;
  endtask
endmodule

// ===== verif/tb.sv
// Purpose: self-checking bench of the converter register bank
// Assumes: ENABLE_RESET left at 1, so control resets to 20h
// Notes:   outputs judged a few cycles after each change
`timescale 1ns/1ps
module tb;
  logic clk = 1'b0, rst = 1'b1, lock = 1'b0, en = 1'b1;
  logic therm = 1'b0, png = 1'b0, sel = 1'b0;
  logic [7:0] addr, wdata, rdata, d;
  logic wr, rd, rng, on, fpm, rpm;
  bbc_pkg::bbc_level_t code;
  bbc_pkg::bbc_rate_e rate;
  logic [12:0] mv;
  int failures = 0, checks = 0;
  always #12.5 clk = ~clk;
  bbc_config_regs u_dut (.clk_i(clk), .sys_rst_i(rst), .supply_lockout_i(lock),
    .enable_pin_i(en), .addr_i(addr), .wr_i(wr), .wdata_i(wdata), .rd_i(rd),
    .rdata_o(rdata), .thermal_fault_i(therm), .power_not_good_i(png),
    .level_select_pin_i(sel), .range_high_o(rng), .converter_on_o(on),
    .forced_pulse_mode_o(fpm), .ramped_pulse_mode_o(rpm), .rate_o(rate),
    .level_code_o(code), .target_mv_o(mv));
  bbc_host_model u_host (.rdata_i(rdata), .clk_i(clk), .addr_o(addr), .wr_o(wr),
    .wdata_o(wdata), .rd_o(rd));
  task automatic chk(input logic [12:0] g, input logic [12:0] e);
    checks++;
    if (g !== e) begin
      failures++;
      $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  // level code lags the level registers by one cycle, target by two
  task automatic settle();
    repeat (3) @(posedge clk);
    #1;
  endtask
  task automatic t_reset();
    logic [7:0] exp [0:6] = '{8'h00, 8'h20, 8'h00, 8'h15, 8'h3c, 8'h42, 8'h00};
    for (int a = 0; a < 7; a++) begin
      u_host.rd(8'(a), d);
      chk(d, exp[a]);
    end
    chk(mv, 13'd3300);
    $display("t_reset done");
  endtask
  task automatic t_ctrl();
    u_host.wr(8'h01, 8'h68);
    settle();
    chk({rng, on, fpm, rpm}, 4'b1110);
    chk(mv, 13'd3525);
    for (int r = 0; r < 4; r++) begin
      u_host.wr(8'h01, 8'h0c | 8'(r));
      settle();
      chk({rng, on, fpm, rpm, rate}, {4'b0011, 2'(r)});
      u_host.rd(8'h01, d);
      chk(d, 8'h0c | 8'(r));
    end
    $display("t_ctrl done");
  endtask
  task automatic t_level();
    u_host.wr(8'h04, 8'hff);
    u_host.rd(8'h04, d);
    chk(d, 8'h7f);
    settle();
    chk(mv, 13'd4975);
    @(posedge clk);
    sel <= 1'b1;
    settle();
    chk(code, 7'h42);
    chk(mv, 13'd3450);
    u_host.wr(8'h05, 8'h00);
    settle();
    chk(mv, 13'd1800);
    @(posedge clk);
    sel <= 1'b0;
    $display("t_level done");
  endtask
  task automatic t_status();
    @(posedge clk);
    therm <= 1'b1;
    png <= 1'b1;
    // fault still standing at the read, so the flag must survive
    u_host.rd(8'h02, d);
    chk(d, 8'h03);
    @(posedge clk);
    therm <= 1'b0;
    u_host.rd(8'h02, d);
    chk(d, 8'h03);
    u_host.rd(8'h02, d);
    chk(d, 8'h01);
    @(posedge clk);
    png <= 1'b0;
    u_host.rd(8'h02, d);
    chk(d, 8'h01);
    u_host.rd(8'h02, d);
    chk(d, 8'h00);
    $display("t_status done");
  endtask
  task automatic t_refuse();
    u_host.wr(8'h02, 8'hff);
    u_host.wr(8'h03, 8'h00);
    u_host.rd(8'h02, d);
    chk(d, 8'h00);
    u_host.rd(8'h03, d);
    chk(d, 8'h15);
    $display("t_refuse done");
  endtask
  task automatic t_volatile();
    u_host.wr(8'h04, 8'h11);
    @(posedge clk);
    lock <= 1'b1;
    @(posedge clk);
    lock <= 1'b0;
    u_host.rd(8'h04, d);
    chk(d, 8'h3c);
    u_host.rd(8'h01, d);
    chk(d, 8'h20);
    u_host.wr(8'h05, 8'h11);
    @(posedge clk);
    en <= 1'b0;
    @(posedge clk);
    en <= 1'b1;
    u_host.rd(8'h05, d);
    chk(d, 8'h42);
    $display("t_volatile done");
  endtask
  task automatic test_done();
    $display("checks=%0d failures=%0d", checks, failures);
    if (failures == 0 && checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  initial begin
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    t_reset();
    t_ctrl();
    t_level();
    t_status();
    t_refuse();
    t_volatile();
    test_done();
  end
  // whole run needs well under 400 cycles
  initial begin
    #100000;
    failures++;
    test_done();
  end
endmodule
